// file: hdl/cbs_pkg.sv
// Constants and types shared by the common register sync bridge
package cbs_pkg;
	localparam int CBS_AW = 8;
	localparam int CBS_DW = 32;
	localparam int CBS_NGEN = 4;
	localparam int CBS_DIVW = 8;
	localparam int CBS_PREW = 4;
	// Register byte offsets
	localparam logic [7:0] CBS_CTRL_OFS = 8'h00;
	localparam logic [7:0] CBS_STATUS_OFS = 8'h04;
	localparam logic [7:0] CBS_RDREQ_OFS = 8'h08;
	localparam logic [7:0] CBS_CFG_OFS = 8'h0c;
	localparam logic [7:0] CBS_COUNT_OFS = 8'h10;
	localparam logic [7:0] CBS_GEN_DIV_OFS = 8'h20;
	localparam logic [7:0] CBS_CLK_SEL_OFS = 8'h30;
	localparam logic [7:0] CBS_PM_OFS = 8'h34;
	// Field positions
	localparam int CBS_SOFT_RESET_BIT_BIT = 0;
	localparam int CBS_ENABLE_BIT = 1;
	localparam int CBS_BUSY_BIT = 0;
	localparam int CBS_READ_REQUEST_BIT_BIT = 15;
	localparam int CBS_PM_MASK_BIT = 0;
	localparam int CBS_PM_CPU_LSB = 8;
	localparam int CBS_PM_BUS_LSB = 12;
	// Values after reset
	localparam logic [31:0] CBS_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] CBS_COUNT_RST = 32'h0000_0000;
	localparam logic [7:0] CBS_GEN_DIV_RST = 8'h00;
	localparam logic [1:0] CBS_CLK_SEL_RST = 2'h0;
	localparam logic [15:0] CBS_PM_RST = 16'h0001;
	localparam logic [3:0] CBS_BE_FULL = 4'hf;
	// Generator that feeds the clock manager
	localparam int CBS_MAIN_GEN = 0;
	// Extra core ticks before a transfer executes
	localparam logic [1:0] CBS_CORE_HOLD = 2'h2;
	typedef enum logic [3:0] {
		CBS_SY_IDLE = 4'h1,
		CBS_SY_WRITE = 4'h2,
		CBS_SY_READ = 4'h4,
		CBS_SY_READ_REQUEST_BIT = 4'h8
	} cbs_sync_state_t;
endpackage

// file: hdl/cbs_core_regs.sv
// Core-clock side of the shared synchronizer and the core registers
`timescale 1ns/100ps
module cbs_core_regs (
	input wire logic clock, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic core_tick, // Generic clock enable
	input wire logic req_tgl, // Request toggle, bus side
	input wire logic req_wr, // Request is a write
	input wire logic [7:0] req_addr, // Request register offset
	input wire logic [31:0] req_data, // Write word, held stable
	output logic ack_tgl, // Completion toggle
	output logic [31:0] rd_data, // Read word for the bus side
	output logic core_enable, // Core enable state
	output logic [31:0] core_count // Core counter value
);
	import cbs_pkg::*;

	logic req_s1_q;
	logic req_s2_q;
	logic seen_q;
	logic pend_q;
	logic [1:0] hold_q;
	logic [31:0] cfg_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end else if (core_tick) begin
			req_s1_q <= req_tgl;
			req_s2_q <= req_s1_q;
		end
	end

	// Hold stretches the transfer past five core periods
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			seen_q <= 1'b0;
			pend_q <= 1'b0;
			hold_q <= 2'h0;
			ack_tgl <= 1'b0;
			rd_data <= 32'h0000_0000;
			core_enable <= 1'b0;
			cfg_q <= CBS_CFG_RST;
			core_count <= CBS_COUNT_RST;
		end else if (core_tick) begin
			if (core_enable) begin
				core_count <= core_count + 32'h0000_0001;
			end
			if (!pend_q && req_s2_q != seen_q) begin
				seen_q <= req_s2_q;
				pend_q <= 1'b1;
				hold_q <= CBS_CORE_HOLD;
			end else if (pend_q && hold_q != 2'h0) begin
				hold_q <= hold_q - 2'h1;
			end else if (pend_q) begin
				pend_q <= 1'b0;
				ack_tgl <= ~ack_tgl;
				if (req_wr) begin
					case (req_addr)
						CBS_CTRL_OFS: begin
							if (req_data[CBS_SOFT_RESET_BIT_BIT]) begin
								core_enable <= 1'b0;
								cfg_q <= CBS_CFG_RST;
								core_count <= CBS_COUNT_RST;
							end else begin
								core_enable <= req_data[CBS_ENABLE_BIT];
							end
						end
						CBS_CFG_OFS: cfg_q <= req_data;
						CBS_COUNT_OFS: core_count <= req_data;
						default: ;
					endcase
				end else begin
					case (req_addr)
						CBS_COUNT_OFS: rd_data <= core_count;
						CBS_CFG_OFS: rd_data <= cfg_q;
						default: rd_data <= 32'h0000_0000;
					endcase
				end
			end
		end
	end
endmodule

// file: hdl/cbs_sync_bridge.sv
// Shared register synchroniser with clock distribution and bus slave
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module cbs_sync_bridge (
	input wire logic clock, // 200 MHz system clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [cbs_pkg::CBS_AW-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [cbs_pkg::CBS_DW-1:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	output logic [cbs_pkg::CBS_DW-1:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall, high while not done
	output logic cpu_clk_en, // Processor clock enable pulse
	output logic bus_clk_en, // Bus clock enable pulse
	output logic iface_clk_en, // Masked interface clock enable
	output logic core_enable, // Core enable state
	output logic [31:0] core_count // Core counter value
);
	import cbs_pkg::*;

	function automatic logic f_is_core(input logic [7:0] a);
		return a == CBS_CTRL_OFS || a == CBS_CFG_OFS || a == CBS_COUNT_OFS;
	endfunction

	function automatic logic f_is_periph(input logic [7:0] a);
		return f_is_core(a) || a == CBS_STATUS_OFS || a == CBS_RDREQ_OFS;
	endfunction

	cbs_sync_state_t sy_state_q;
	logic busy_q;
	logic req_tgl_q;
	logic req_wr_q;
	logic [7:0] req_addr_q;
	logic [31:0] req_data_q;
	logic ack_tgl;
	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_seen_q;
	logic [31:0] core_rd;
	logic ctrl_enable_q;
	logic ctrl_soft_reset_bit_q;
	logic [31:0] cfg_shadow_q;
	logic [7:0] rr_addr_q;
	logic [31:0] cache_q;
	logic cache_valid_q;
	logic [7:0] gen_div_q [CBS_NGEN];
	logic [7:0] gen_cnt_q [CBS_NGEN];
	logic [CBS_NGEN-1:0] gen_tick_q;
	logic [1:0] clk_sel_q;
	logic [15:0] pm_q;
	logic [3:0] cpu_pre_q;
	logic [3:0] bus_pre_q;
	logic core_tick_q;
	logic done;
	logic acc_v;
	logic wr_ok;
	logic [31:0] bus_rd;
	logic [7:0] gen_ofs;

	generate
		for (genvar g = 0; g < CBS_NGEN; g++) begin : g_gen
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					gen_cnt_q[g] <= 8'h00;
					gen_tick_q[g] <= 1'b0;
				end else if (gen_cnt_q[g] >= gen_div_q[g]) begin
					gen_cnt_q[g] <= 8'h00;
					gen_tick_q[g] <= 1'b1;
				end else begin
					gen_cnt_q[g] <= gen_cnt_q[g] + 8'h01;
					gen_tick_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cpu_pre_q <= 4'h0;
			bus_pre_q <= 4'h0;
			cpu_clk_en <= 1'b0;
			bus_clk_en <= 1'b0;
			iface_clk_en <= 1'b0;
		end else begin
			cpu_clk_en <= 1'b0;
			bus_clk_en <= 1'b0;
			iface_clk_en <= 1'b0;
			if (gen_tick_q[CBS_MAIN_GEN]) begin
				// prescalers divide by field plus one
				if (cpu_pre_q >= pm_q[CBS_PM_CPU_LSB +: CBS_PREW]) begin
					cpu_pre_q <= 4'h0;
					cpu_clk_en <= 1'b1;
				end else begin
					cpu_pre_q <= cpu_pre_q + 4'h1;
				end
				if (bus_pre_q >= pm_q[CBS_PM_BUS_LSB +: CBS_PREW]) begin
					bus_pre_q <= 4'h0;
					bus_clk_en <= 1'b1;
					iface_clk_en <= pm_q[CBS_PM_MASK_BIT];
				end else begin
					bus_pre_q <= bus_pre_q + 4'h1;
				end
			end
		end
	end

	// generator multiplexer for the core clock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			core_tick_q <= 1'b0;
		end else begin
			core_tick_q <= gen_tick_q[clk_sel_q];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl;
			ack_s2_q <= ack_s1_q;
		end
	end

	always_comb begin
		done = ack_s2_q != ack_seen_q;
		// Masked interface parks peripheral accesses
		acc_v = (avs_read || avs_write) && avs_waitrequest && !done &&
			(pm_q[CBS_PM_MASK_BIT] || !f_is_periph(avs_address));
		wr_ok = avs_byteenable == CBS_BE_FULL;
		gen_ofs = avs_address - CBS_GEN_DIV_OFS;
		bus_rd = 32'h0000_0000;
		case (avs_address)
			CBS_CTRL_OFS: begin
				bus_rd[CBS_SOFT_RESET_BIT_BIT] = ctrl_soft_reset_bit_q;
				bus_rd[CBS_ENABLE_BIT] = ctrl_enable_q;
			end
			CBS_STATUS_OFS: bus_rd[CBS_BUSY_BIT] = busy_q;
			CBS_RDREQ_OFS: bus_rd[7:0] = rr_addr_q;
			CBS_CFG_OFS: bus_rd = cfg_shadow_q;
			CBS_CLK_SEL_OFS: bus_rd[1:0] = clk_sel_q;
			CBS_PM_OFS: bus_rd[15:0] = pm_q;
			default: begin
				if (avs_address[7:4] == CBS_GEN_DIV_OFS[7:4] &&
					avs_address[1:0] == 2'h0) begin
					bus_rd[7:0] = gen_div_q[gen_ofs[3:2]];
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sy_state_q <= CBS_SY_IDLE;
			busy_q <= 1'b0;
			req_tgl_q <= 1'b0;
			req_wr_q <= 1'b0;
			req_addr_q <= 8'h00;
			req_data_q <= 32'h0000_0000;
			ack_seen_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			ctrl_enable_q <= 1'b0;
			ctrl_soft_reset_bit_q <= 1'b0;
			cfg_shadow_q <= CBS_CFG_RST;
			rr_addr_q <= 8'h00;
			cache_q <= 32'h0000_0000;
			cache_valid_q <= 1'b0;
			for (int g = 0; g < CBS_NGEN; g++) begin
				gen_div_q[g] <= CBS_GEN_DIV_RST;
			end
			clk_sel_q <= CBS_CLK_SEL_RST;
			pm_q <= CBS_PM_RST;
		end else begin
			if (!avs_waitrequest) begin
				avs_waitrequest <= 1'b1;
			end
			if (done) begin
				ack_seen_q <= ack_s2_q;
				sy_state_q <= CBS_SY_IDLE;
				unique case (sy_state_q)
					CBS_SY_WRITE: begin
						busy_q <= 1'b0;
						if (ctrl_soft_reset_bit_q) begin
							ctrl_soft_reset_bit_q <= 1'b0;
							ctrl_enable_q <= 1'b0;
							cfg_shadow_q <= CBS_CFG_RST;
						end
					end
					CBS_SY_READ: begin
						avs_readdata <= core_rd;
						avs_waitrequest <= 1'b0;
					end
					CBS_SY_READ_REQUEST_BIT: begin
						busy_q <= 1'b0;
						cache_q <= core_rd;
						cache_valid_q <= 1'b1;
					end
					CBS_SY_IDLE: ;
				endcase
			end else if (acc_v && avs_read) begin
				if (avs_address == CBS_COUNT_OFS) begin
					if (cache_valid_q && rr_addr_q == CBS_COUNT_OFS) begin
						avs_readdata <= cache_q;
						avs_waitrequest <= 1'b0;
					// own read sync only after idle
					end else if (sy_state_q == CBS_SY_IDLE) begin
						sy_state_q <= CBS_SY_READ;
						req_tgl_q <= ~req_tgl_q;
						req_wr_q <= 1'b0;
						req_addr_q <= avs_address;
					end
				// read of CFG waits while a busy transfer targets CFG
				end else if (!(busy_q && req_addr_q == avs_address &&
					avs_address == CBS_CFG_OFS)) begin
					avs_readdata <= bus_rd;
					avs_waitrequest <= 1'b0;
				end
			end else if (acc_v && avs_write) begin
				if (f_is_core(avs_address)) begin
					// write held while a transfer runs
					if (sy_state_q == CBS_SY_IDLE) begin
						avs_waitrequest <= 1'b0;
						if (wr_ok) begin
							sy_state_q <= CBS_SY_WRITE;
							busy_q <= 1'b1;
							req_tgl_q <= ~req_tgl_q;
							req_wr_q <= 1'b1;
							req_addr_q <= avs_address;
							req_data_q <= avs_writedata;
							cache_valid_q <= 1'b0;
							if (avs_address == CBS_CFG_OFS) begin
								cfg_shadow_q <= avs_writedata;
							end
							if (avs_address == CBS_CTRL_OFS) begin
								// soft reset reads one at once
								if (avs_writedata[CBS_SOFT_RESET_BIT_BIT]) begin
									ctrl_soft_reset_bit_q <= 1'b1;
								end else begin
									ctrl_enable_q <=
										avs_writedata[CBS_ENABLE_BIT];
								end
							end
						end
					end
				end else if (avs_address == CBS_RDREQ_OFS) begin
					if (!wr_ok || !avs_writedata[CBS_READ_REQUEST_BIT_BIT]) begin
						avs_waitrequest <= 1'b0;
						if (wr_ok) begin
							rr_addr_q <= avs_writedata[7:0];
						end
					end else if (sy_state_q == CBS_SY_IDLE) begin
						avs_waitrequest <= 1'b0;
						rr_addr_q <= avs_writedata[7:0];
						cache_valid_q <= 1'b0;
						sy_state_q <= CBS_SY_READ_REQUEST_BIT;
						busy_q <= 1'b1;
						req_tgl_q <= ~req_tgl_q;
						req_wr_q <= 1'b0;
						req_addr_q <= avs_writedata[7:0];
					end
				end else begin
					avs_waitrequest <= 1'b0;
					if (wr_ok && avs_address == CBS_CLK_SEL_OFS) begin
						clk_sel_q <= avs_writedata[1:0];
					end
					if (wr_ok && avs_address == CBS_PM_OFS) begin
						pm_q <= avs_writedata[15:0];
					end
					if (wr_ok && avs_address[7:4] == CBS_GEN_DIV_OFS[7:4] &&
						avs_address[1:0] == 2'h0) begin
						gen_div_q[gen_ofs[3:2]] <= avs_writedata[7:0];
					end
				end
			end
		end
	end

	// core side always runs the handshake
	cbs_core_regs u_core (
		.clock(clock),
		.reset_n(reset_n),
		.core_tick(core_tick_q),
		.req_tgl(req_tgl_q),
		.req_wr(req_wr_q),
		.req_addr(req_addr_q),
		.req_data(req_data_q),
		.ack_tgl(ack_tgl),
		.rd_data(core_rd),
		.core_enable(core_enable),
		.core_count(core_count)
	);

	// Checks
	AST_ONE_IN_FLIGHT: assert property (@(posedge clock) disable iff (!reset_n)
		$changed(req_tgl_q) |-> $past(sy_state_q) == CBS_SY_IDLE)
		else $error("second transfer started while one in flight");
	AST_WRITE_BUSY: assert property (@(posedge clock) disable iff (!reset_n)
		acc_v && avs_write && wr_ok && f_is_core(avs_address) &&
		sy_state_q == CBS_SY_IDLE |=> busy_q && $changed(req_tgl_q))
		else $error("core write did not start a busy transfer");
	AST_BUSY_DROP: assert property (@(posedge clock) disable iff (!reset_n)
		done && sy_state_q == CBS_SY_WRITE |=> !busy_q)
		else $error("busy stayed high after write completion");
	AST_STALL_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
		busy_q && !done && avs_write && avs_waitrequest &&
		f_is_core(avs_address) |=> avs_waitrequest)
		else $error("core write completed during a transfer");
	AST_READ_NO_BUSY: assert property (@(posedge clock) disable iff (!reset_n)
		sy_state_q == CBS_SY_READ |-> !busy_q)
		else $error("read sync raised busy");
	AST_BUS_REG_FAST: assert property (@(posedge clock) disable iff (!reset_n)
		avs_read && avs_waitrequest && !done &&
		avs_address == CBS_STATUS_OFS && pm_q[CBS_PM_MASK_BIT]
		|=> !avs_waitrequest)
		else $error("status read was stalled");
	AST_ENABLE_NOW: assert property (@(posedge clock) disable iff (!reset_n)
		acc_v && avs_write && wr_ok && avs_address == CBS_CTRL_OFS &&
		sy_state_q == CBS_SY_IDLE && !avs_writedata[CBS_SOFT_RESET_BIT_BIT]
		|=> ctrl_enable_q == $past(avs_writedata[CBS_ENABLE_BIT]))
		else $error("enable did not read back at once");
	AST_SOFT_RESET_BIT_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
		ctrl_soft_reset_bit_q && !done |=> ctrl_soft_reset_bit_q && busy_q)
		else $error("soft reset dropped before completion");
	AST_DATA_STABLE: assert property (@(posedge clock) disable iff (!reset_n)
		sy_state_q != CBS_SY_IDLE && !done |=> $stable(req_data_q))
		else $error("request word moved during a transfer");
	COV_WRITE: cover property (@(posedge clock) disable iff (!reset_n)
		sy_state_q == CBS_SY_WRITE && done);
	COV_READ: cover property (@(posedge clock) disable iff (!reset_n)
		sy_state_q == CBS_SY_READ && done);
	COV_READ_REQUEST_BIT: cover property (@(posedge clock) disable iff (!reset_n)
		sy_state_q == CBS_SY_READ_REQUEST_BIT && done);
endmodule

// file: verif/cbs_master.sv
// Avalon-MM master model standing in for the processor
`timescale 1ns/100ps
module cbs_master (
	input wire logic clock, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic start, // Begin one access
	input wire logic start_wr, // Access is a write
	input wire logic [7:0] start_addr, // Access byte address
	input wire logic [31:0] start_data, // Write word
	input wire logic [3:0] start_be, // Write byte enables
	output logic avs_read, // Read request
	output logic avs_write, // Write request
	output logic [7:0] avs_address, // Byte address
	output logic [31:0] avs_writedata, // Write data
	output logic [3:0] avs_byteenable, // Byte enables
	input wire logic avs_waitrequest, // Slave stall
	input wire logic [31:0] avs_readdata, // Slave read data
	output logic done, // Pulse after an access ends
	output logic was_rd, // Finished access was a read
	output logic [31:0] rdata, // Word taken at completion
	output logic [15:0] waits // Stalled edges of last access
);
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			avs_address <= 8'h00;
			avs_writedata <= 32'h0;
			avs_byteenable <= 4'h0;
			done <= 1'b0;
			was_rd <= 1'b0;
			rdata <= 32'h0;
			waits <= 16'h0;
		end else begin
			done <= 1'b0;
			if (avs_read || avs_write) begin
				if (!avs_waitrequest) begin
					avs_read <= 1'b0;
					avs_write <= 1'b0;
					// Released lines flip so stale values never look valid
					avs_address <= ~avs_address;
					avs_writedata <= ~avs_writedata;
					done <= 1'b1;
					was_rd <= avs_read;
					rdata <= avs_readdata;
				end else begin
					waits <= waits + 16'h1;
				end
			end else if (start) begin
				avs_read <= !start_wr;
				avs_write <= start_wr;
				avs_address <= start_addr;
				avs_writedata <= start_data;
				avs_byteenable <= start_be;
				waits <= 16'h0;
			end
		end
	end
endmodule

// file: verif/cbs_sync_bridge_tb.sv
// Self-checking bench for the common register sync bridge
`timescale 1ns/100ps
module cbs_sync_bridge_tb;
	import cbs_pkg::*;
	typedef struct {
		logic [31:0] exp;
		logic [31:0] msk;
	} cbs_exp_t;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic start_wr = 1'b0;
	logic [7:0] start_addr = 8'h00;
	logic [31:0] start_data = 32'h0;
	logic [3:0] start_be = 4'hf;
	logic avs_read, avs_write, avs_waitrequest, done, was_rd;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata, core_count, wd;
	logic [3:0] avs_byteenable;
	logic [15:0] waits;
	logic cpu_clk_en, bus_clk_en, iface_clk_en, core_enable;
	int err_count = 0;
	int compares = 0;
	int seed = 32'hbe383b4c;
	int n_cpu, n_bus, n_if;
	cbs_exp_t exp_q[$];
	cbs_exp_t mon_e;
	logic [7:0] ofs[10] = '{8'h04, 8'h08, 8'h0c, 8'h20, 8'h24, 8'h28,
		8'h2c, 8'h30, 8'h34, 8'h3c};
	logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h1, 32'h0};

	always #2.5 clock = ~clock;

	cbs_sync_bridge dut_u (.clock(clock), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpu_clk_en(cpu_clk_en),
		.bus_clk_en(bus_clk_en), .iface_clk_en(iface_clk_en),
		.core_enable(core_enable), .core_count(core_count));

	cbs_master mst_u (.clock(clock), .reset_n(reset_n), .start(start),
		.start_wr(start_wr), .start_addr(start_addr),
		.start_data(start_data), .start_be(start_be),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_address(avs_address), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.done(done), .was_rd(was_rd), .rdata(rdata), .waits(waits));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int i;
		@(posedge clock);
		start <= 1'b1;
		start_wr <= w;
		start_addr <= a;
		start_data <= d;
		start_be <= be;
		@(posedge clock);
		start <= 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++)
			@(negedge clock);
		if (done !== 1'b1) begin
			err_count++;
			wrap_up();
		end
	endtask

	// Expectation noted before the read goes out
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back('{e, m});
		acc(1'b0, a, 32'h0, 4'hf);
	endtask

	task automatic stall(input logic s, input string what);
		check({31'h0, waits > 16'd1}, {31'h0, s}, what);
	endtask

	task automatic poll_idle();
		int i;
		for (i = 0; i < 60; i++) begin
			rd(CBS_STATUS_OFS, 32'h0, 32'h0);
			if (rdata[CBS_BUSY_BIT] === 1'b0)
				break;
		end
		check({31'h0, rdata[CBS_BUSY_BIT]}, 32'h0, "busy poll");
	endtask

	task automatic pulses(input int n);
		n_cpu = 0;
		n_bus = 0;
		n_if = 0;
		repeat (n) begin
			@(negedge clock);
			n_cpu += cpu_clk_en;
			n_bus += bus_clk_en;
			n_if += iface_clk_en;
		end
	endtask

	// Read results are judged as they complete
	always @(negedge clock) begin
		if (done === 1'b1 && was_rd === 1'b1) begin
			if (exp_q.size() > 0) begin
				mon_e = exp_q.pop_front();
				check(rdata & mon_e.msk, mon_e.exp & mon_e.msk, "readdata");
			end else begin
				check(32'h1, 32'h0, "unexpected read");
			end
		end
	end

	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		acc(1'b1, 8'h3c, 32'hffff_ffff, 4'hf);
		for (int k = 0; k < 10; k++) begin
			rd(ofs[k], rv[k], 32'hffff_ffff);
			stall(1'b0, "bus-side read");
		end
		rd(CBS_COUNT_OFS, 32'h0, 32'hffff_ffff);
		check({31'h0, waits >= 16'd7 && waits <= 16'd11}, 32'h1, "rd delay");
		// Prescalers fed by generator zero
		acc(1'b1, CBS_PM_OFS, 32'h0000_3101, 4'hf);
		pulses(40);
		check(n_cpu, 32'd20, "cpu pulses");
		check(n_bus, 32'd10, "bus pulses");
		check(n_if, 32'd10, "iface pulses");
		acc(1'b1, CBS_GEN_DIV_OFS, 32'h1, 4'hf);
		acc(1'b1, CBS_PM_OFS, 32'h0000_3100, 4'hf);
		pulses(40);
		check(n_cpu, 32'd10, "cpu pulses gen0");
		check(n_bus, 32'd5, "bus pulses gen0");
		check(n_if, 32'd0, "masked iface");
		acc(1'b1, CBS_PM_OFS, 32'h1, 4'hf);
		acc(1'b1, CBS_GEN_DIV_OFS, 32'h0, 4'hf);
		// Slow generator one as core clock stretches the sync
		acc(1'b1, CBS_GEN_DIV_OFS + 8'h04, 32'h3, 4'hf);
		acc(1'b1, CBS_CLK_SEL_OFS, 32'h1, 4'hf);
		acc(1'b1, CBS_CFG_OFS, 32'h5, 4'hf);
		acc(1'b1, CBS_CFG_OFS, 32'h6, 4'hf);
		check({31'h0, waits >= 16'd16}, 32'h1, "slow core stall");
		poll_idle();
		acc(1'b1, CBS_CLK_SEL_OFS, 32'h0, 4'hf);
		repeat (2) begin
			wd = $random(seed);
			acc(1'b1, CBS_CFG_OFS, wd, 4'hf);
			stall(1'b0, "cfg write ack");
			rd(CBS_STATUS_OFS, 32'h1, 32'h1);
			stall(1'b0, "status during sync");
			rd(CBS_CFG_OFS, wd, 32'hffff_ffff);
			stall(1'b1, "read of written reg");
			poll_idle();
		end
		wd = $random(seed);
		acc(1'b1, CBS_CFG_OFS, wd, 4'hf);
		acc(1'b1, CBS_CTRL_OFS, 32'h2, 4'hf);
		stall(1'b1, "core write while busy");
		rd(CBS_CTRL_OFS, 32'h2, 32'h3);
		stall(1'b0, "enable readback");
		rd(CBS_COUNT_OFS, 32'h0, 32'h0);
		check({31'h0, waits >= 16'd10}, 32'h1, "double stall");
		acc(1'b1, CBS_CTRL_OFS, 32'h2, 4'hf);
		rd(CBS_CFG_OFS, wd, 32'hffff_ffff);
		stall(1'b0, "static core read");
		poll_idle();
		check({31'h0, core_enable}, 32'h1, "core enable");
		// Read request on a frozen counter
		acc(1'b1, CBS_CTRL_OFS, 32'h0, 4'hf);
		poll_idle();
		// Known count value so the cached read can be judged
		wd = $random(seed);
		acc(1'b1, CBS_COUNT_OFS, wd, 4'hf);
		poll_idle();
		acc(1'b1, CBS_RDREQ_OFS, 32'h0000_8010, 4'hf);
		stall(1'b0, "read request ack");
		rd(CBS_STATUS_OFS, 32'h1, 32'h1);
		poll_idle();
		rd(CBS_COUNT_OFS, wd, 32'hffff_ffff);
		stall(1'b0, "cached count");
		rd(CBS_RDREQ_OFS, 32'h0, 32'h8000);
		// Soft reset clears core and shadow state
		acc(1'b1, CBS_CTRL_OFS, 32'h1, 4'hf);
		rd(CBS_CTRL_OFS, 32'h1, 32'h1);
		poll_idle();
		rd(CBS_CTRL_OFS, 32'h0, 32'h3);
		rd(CBS_CFG_OFS, 32'h0, 32'hffff_ffff);
		rd(CBS_COUNT_OFS, 32'h0, 32'hffff_ffff);
		check({31'h0, waits >= 16'd7 && waits <= 16'd11}, 32'h1, "rd delay");
		check({31'h0, core_enable}, 32'h0, "enable after reset");
		check(core_count, 32'h0, "count after reset");
		acc(1'b1, CBS_CFG_OFS, $random(seed), 4'h3);
		rd(CBS_STATUS_OFS, 32'h0, 32'h1);
		rd(CBS_CFG_OFS, 32'h0, 32'hffff_ffff);
		repeat (3) @(negedge clock);
		check(exp_q.size(), 32'h0, "pending reads");
		wrap_up();
	end
endmodule
